// ==== inc/smbus_pkg.sv ====
// constants and types shared by both ends of the two-wire client link
// assumes one 100 MHz clock and bus pins sampled as synchronous inputs
package smbus_pkg;

  // ==========================================================
  // addressing and framing
  localparam logic [6:0] CLIENT_ADDR = 7'h28;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] FRAME_BITS  = 4'h9;
  localparam logic       PIN_LOW     = 1'h0;

  // ==========================================================
  // timing
  localparam int MCLK_PERIOD_NS = 10;
  localparam int TIMEOUT_LOW_MS = 30;
  localparam int IDLE_HIGH_US   = 200;
  localparam int SCL_PERIOD_NS  = 2500;
  localparam int TIMEOUT_CYC    =
    (TIMEOUT_LOW_MS * 1000000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int IDLE_CYC       =
    (IDLE_HIGH_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int QUARTER_CYC    =
    (SCL_PERIOD_NS / 4 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int TCNT_W         = 22;
  localparam int DIV_W          = 8;

  // ==========================================================
  // quarter phases of one bit on the host side
  localparam logic [1:0] Q_SETUP   = 2'h0;
  localparam logic [1:0] Q_RISE    = 2'h1;
  localparam logic [1:0] Q_SAMPLE  = 2'h2;
  localparam logic [1:0] Q_FALL    = 2'h3;

  // ==========================================================
  // host operations
  typedef enum logic [2:0] {
    OP_START, OP_WRITE, OP_READ_ACK, OP_READ_NACK, OP_STOP
  } op_t;

endpackage

// ==== inc/smbus_if.sv ====
// open-drain two-wire bus joining the host end and the client end
// assumes each party pulls a line low only while its enable is high
`timescale 1ns/1ns
`default_nettype none
interface smbus_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic serial_clock_pin;
  logic sda_pin;

  // wired-and with pull-ups
  assign serial_clock_pin = !(host_scl_oe && !host_scl_o);
  assign sda_pin = !(host_sda_oe && !host_sda_o) &&
                   !(dev_sda_oe && !dev_sda_o);

  modport device (input serial_clock_pin, sda_pin,
                  output dev_sda_o, dev_sda_oe);
  modport host (input serial_clock_pin, sda_pin,
                output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe);
endinterface
`default_nettype wire

// ==== hw/smbus_client.sv ====
// client end of the two-wire link: framing, address match, register port
// assumes bus pins synchronous to MCLK and a register file outside
// Function
// - never stretch clock, tolerate host stretching
// - data falling while clock high starts
// - first byte: address then direction bit
// - bytes are eight bits, MSB first
// - answer only the fixed client address
// - acknowledge every received byte
// - host acknowledges all but last read byte
// - stop resets client state machine
// - clock low too long aborts transfer
// - timeout feature off unless enabled
// - both lines high too long resets
// - plain framing, no byte count field
// - no alert response address handling
// - write byte: index, data, stored there
// - read byte: index, restart, one byte
// - index-only write loads the pointer
// - direct read returns byte at pointer
// - deep sleep blocks index-only pointer load
// - deep sleep refuses direct read
// - block read streams bytes until not-acknowledge
// - read pointer advances, wraps to zero
// - block write stores, advances, wraps
// - addressed traffic wakes, sleep bit kept
`timescale 1ns/1ns
`default_nettype none
module smbus_client
  import smbus_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int unsigned IDLE_CYCLES    = IDLE_CYC
) (
  // clock and reset
  input  wire logic MCLK,
  input  wire logic RST_N,
  // bus
  smbus_if.device   BUS,
  // controls from the register file
  input  wire logic DEEP_SLEEP_BIT,
  input  wire logic TIMEOUT_EN,
  // register file port
  output logic [7:0] REG_RADDR,
  input  wire logic [7:0] REG_RDATA,
  output logic       REG_RE,
  output logic [7:0] REG_WADDR,
  output logic [7:0] REG_WDATA,
  output logic       REG_WE,
  // status
  output logic       AWAKE
);

  // ==========================================================
  // state
  typedef enum logic [2:0] {
    S_IDLE, S_RX, S_RX_ACK, S_TX, S_TX_ACK, S_IGNORE
  } dev_state_t;

  typedef enum logic [1:0] {K_ADDR, K_INDEX, K_DATA} kind_t;

  typedef struct packed {
    dev_state_t        st;
    kind_t             kind;
    logic [7:0]        sh;
    logic [3:0]        bits;
    logic              rd;
    logic              ack_ok;
    logic [7:0]        ptr;
    logic [7:0]        idx;
    logic              idx_pend;
    logic              idx_seen;
    logic              sda_oe;
    logic              scl_p;
    logic              sda_p;
    logic [TCNT_W-1:0] tcnt;
    logic              awake;
    logic              we;
    logic              re;
    logic [7:0]        waddr;
    logic [7:0]        wdata;
  } dstate_t;

  dstate_t s_reg;
  dstate_t s_next;

  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic tmo;
  logic load;
  logic ack;

  assign scl = BUS.serial_clock_pin;
  assign sda = BUS.sda_pin;

  // ==========================================================
  // next state
  always_comb begin
    s_next = s_reg;
    s_next.we = 1'b0;
    s_next.re = 1'b0;
    s_next.scl_p = scl;
    s_next.sda_p = sda;
    load = 1'b0;
    ack = 1'b0;

    // pins are plain inputs, so a clock held low by the host is waited out
    rise = scl && !s_reg.scl_p;
    fall = !scl && s_reg.scl_p;
    start = scl && s_reg.scl_p && s_reg.sda_p && !sda;
    stop = scl && s_reg.scl_p && !s_reg.sda_p && sda;

    // any edge on either line restarts the quiet-time count
    if (!TIMEOUT_EN || (scl != s_reg.scl_p) || (sda != s_reg.sda_p)) begin
      s_next.tcnt = '0;
    end else if (s_reg.tcnt != '1) begin
      s_next.tcnt = s_reg.tcnt + 1'b1;
    end
    tmo = TIMEOUT_EN &&
          ((!scl && s_reg.tcnt >= TCNT_W'(TIMEOUT_CYCLES - 1)) ||
           (scl && sda && s_reg.tcnt >= TCNT_W'(IDLE_CYCLES - 1)));

    if (start) begin
      // a restart after an index commits the pointer for the read
      if (s_reg.st != S_IDLE && s_reg.idx_pend) begin
        s_next.ptr = s_reg.idx;
        s_next.idx_pend = 1'b0;
      end
      s_next.st = S_RX;
      s_next.kind = K_ADDR;
      s_next.bits = '0;
      s_next.rd = 1'b0;
      s_next.sda_oe = 1'b0;
    end else if (stop || tmo) begin
      if (stop && s_reg.idx_pend && !DEEP_SLEEP_BIT) begin
        s_next.ptr = s_reg.idx;
      end
      s_next.st = S_IDLE;
      s_next.idx_pend = 1'b0;
      s_next.idx_seen = 1'b0;
      s_next.sda_oe = 1'b0;
      s_next.awake = 1'b0;
    end else begin
      unique case (s_reg.st)
        S_IDLE, S_IGNORE: begin
        end
        S_RX: begin
          if (rise && s_reg.bits != BYTE_BITS) begin
            s_next.sh = {s_reg.sh[6:0], sda};
            s_next.bits = s_reg.bits + 1'b1;
          end else if (fall && s_reg.bits == BYTE_BITS) begin
            unique case (s_reg.kind)
              K_ADDR: begin
                // only the fixed address; the alert address is not decoded
                if (s_reg.sh[7:1] == CLIENT_ADDR &&
                    !(s_reg.sh[0] && !s_reg.idx_seen && DEEP_SLEEP_BIT)) begin
                  ack = 1'b1;
                  s_next.rd = s_reg.sh[0];
                  s_next.kind = K_INDEX;
                  s_next.awake = 1'b1;
                end else begin
                  s_next.st = S_IGNORE;
                end
              end
              K_INDEX: begin
                ack = 1'b1;
                s_next.idx = s_reg.sh;
                s_next.idx_pend = 1'b1;
                s_next.idx_seen = 1'b1;
                s_next.kind = K_DATA;
              end
              K_DATA: begin
                // no count byte: every further byte is data
                ack = 1'b1;
                s_next.we = 1'b1;
                s_next.waddr = s_reg.idx_pend ? s_reg.idx : s_reg.ptr;
                s_next.wdata = s_reg.sh;
                s_next.ptr = s_next.waddr + 8'h01;
                s_next.idx_pend = 1'b0;
              end
              default: begin
                s_next.st = S_IGNORE;
              end
            endcase
            if (ack) begin
              s_next.st = S_RX_ACK;
              s_next.sda_oe = 1'b1;
            end
          end
        end
        S_RX_ACK: begin
          if (fall) begin
            s_next.sda_oe = 1'b0;
            s_next.bits = '0;
            if (s_reg.rd) begin
              load = 1'b1;
            end else begin
              s_next.st = S_RX;
            end
          end
        end
        S_TX: begin
          if (fall) begin
            if (s_reg.bits == BYTE_BITS) begin
              s_next.sda_oe = 1'b0;
              s_next.st = S_TX_ACK;
            end else begin
              s_next.sh = {s_reg.sh[6:0], 1'b0};
              s_next.sda_oe = !s_reg.sh[6];
              s_next.bits = s_reg.bits + 1'b1;
            end
          end
        end
        S_TX_ACK: begin
          if (rise) begin
            s_next.ack_ok = !sda;
          end else if (fall) begin
            if (s_reg.ack_ok) begin
              load = 1'b1;
            end else begin
              s_next.st = S_IGNORE;
            end
          end
        end
        default: begin
          s_next.st = S_IDLE;
        end
      endcase
    end

    // fetch at the pointer, drive its MSB, step the pointer with wrap
    if (load) begin
      s_next.sh = REG_RDATA;
      s_next.re = 1'b1;
      s_next.ptr = s_reg.ptr + 8'h01;
      s_next.sda_oe = !REG_RDATA[7];
      s_next.bits = 4'h1;
      s_next.st = S_TX;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s_reg <= '{st: S_IDLE, kind: K_ADDR, scl_p: 1'b1, sda_p: 1'b1,
                 default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs; the clock line is never driven here
  assign BUS.dev_sda_o = PIN_LOW;
  assign BUS.dev_sda_oe = s_reg.sda_oe;
  assign REG_RADDR = s_reg.ptr;
  assign REG_RE = s_reg.re;
  assign REG_WADDR = s_reg.waddr;
  assign REG_WDATA = s_reg.wdata;
  assign REG_WE = s_reg.we;
  assign AWAKE = s_reg.awake;

endmodule
`default_nettype wire

// ==== hw/smbus_host.sv ====
// host end of the two-wire link: byte-level operations on command
// assumes the client never stretches; host waits on a low clock anyway
`timescale 1ns/1ns
`default_nettype none
module smbus_host
  import smbus_pkg::*;
#(
  parameter int unsigned QUARTER_CYCLES = QUARTER_CYC
) (
  // clock and reset
  input  wire logic  MCLK,
  input  wire logic  RST_N,
  // bus
  smbus_if.host      BUS,
  // operation request
  input  wire logic  OP_VALID,
  output logic       OP_READY,
  input  wire op_t   OP_CODE,
  input  wire logic [7:0] OP_WDATA,
  // results
  output logic       DONE,
  output logic [7:0] RD_DATA,
  output logic       ACKED
);

  // ==========================================================
  // state
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;

  typedef struct packed {
    host_state_t      st;
    op_t              op;
    logic [1:0]       q;
    logic [3:0]       bits;
    logic [7:0]       sh;
    logic [DIV_W-1:0] div;
    logic             scl_low;
    logic             sda_low;
    logic             done;
    logic [7:0]       rdata;
    logic             acked;
  } hstate_t;

  hstate_t h_reg;
  hstate_t h_next;

  logic tick;
  logic stall;
  logic last_q;

  always_comb begin
    h_next = h_reg;
    h_next.done = 1'b0;
    tick = (h_reg.div == DIV_W'(QUARTER_CYCLES - 1));
    // clock released but held low by someone: wait before sampling
    stall = (h_reg.q == Q_SAMPLE) && !BUS.serial_clock_pin;
    last_q = 1'b0;

    if (h_reg.st == H_IDLE) begin
      h_next.div = '0;
      if (OP_VALID) begin
        h_next.op = OP_CODE;
        h_next.q = Q_SETUP;
        h_next.bits = '0;
        h_next.sh = OP_WDATA;
        unique case (OP_CODE)
          OP_START: h_next.st = H_START;
          OP_STOP: h_next.st = H_STOP;
          default: h_next.st = H_BIT;
        endcase
      end
    end else if (!tick) begin
      h_next.div = h_reg.div + 1'b1;
    end else if (!stall) begin
      h_next.div = '0;
      h_next.q = h_reg.q + 1'b1;
      last_q = (h_reg.q == Q_FALL);
      unique case (h_reg.st)
        H_START: begin
          unique case (h_reg.q)
            Q_SETUP: h_next.sda_low = 1'b0;
            Q_RISE: h_next.scl_low = 1'b0;
            Q_SAMPLE: h_next.sda_low = 1'b1;
            Q_FALL: h_next.scl_low = 1'b1;
          endcase
        end
        H_STOP: begin
          unique case (h_reg.q)
            Q_SETUP: h_next.sda_low = 1'b1;
            Q_RISE: h_next.scl_low = 1'b0;
            Q_SAMPLE: h_next.sda_low = 1'b0;
            Q_FALL: begin
            end
          endcase
        end
        H_BIT: begin
          unique case (h_reg.q)
            Q_SETUP: begin
              if (h_reg.bits != BYTE_BITS) begin
                h_next.sda_low = (h_reg.op == OP_WRITE) && !h_reg.sh[7];
              end else begin
                // last byte of a read is left unacknowledged
                h_next.sda_low = (h_reg.op == OP_READ_ACK);
              end
            end
            Q_RISE: h_next.scl_low = 1'b0;
            Q_SAMPLE: begin
              if (h_reg.bits != BYTE_BITS) begin
                h_next.sh = {h_reg.sh[6:0], BUS.sda_pin};
              end else begin
                h_next.acked = !BUS.sda_pin;
              end
            end
            Q_FALL: begin
              h_next.scl_low = 1'b1;
              h_next.bits = h_reg.bits + 1'b1;
            end
          endcase
          last_q = last_q && (h_reg.bits + 1'b1 == FRAME_BITS);
          if (last_q) begin
            h_next.rdata = h_reg.sh;
            h_next.sda_low = 1'b0;
          end
        end
        default: begin
        end
      endcase
      if (last_q) begin
        h_next.st = H_IDLE;
        h_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      h_reg <= '{st: H_IDLE, op: OP_START, default: '0};
    end else begin
      h_reg <= h_next;
    end
  end

  // ==========================================================
  // outputs
  assign OP_READY = (h_reg.st == H_IDLE);
  assign DONE = h_reg.done;
  assign RD_DATA = h_reg.rdata;
  assign ACKED = h_reg.acked;
  assign BUS.host_scl_o = PIN_LOW;
  assign BUS.host_scl_oe = h_reg.scl_low;
  assign BUS.host_sda_o = PIN_LOW;
  assign BUS.host_sda_oe = h_reg.sda_low;

endmodule
`default_nettype wire

// ==== testbench/smbus_chk.sv ====
// assertions on the two-wire bus between host and client ends
// assumes interface nets and the timeout enable as plain inputs
`timescale 1ns/1ns
`default_nettype none
module smbus_chk
  import smbus_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // bus nets
  input wire logic host_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic serial_clock_pin,
  input wire logic sda_pin,
  // control
  input wire logic TIMEOUT_EN
);
  // =====
  // bus decode
  logic       scl_q;
  logic       sda_q;
  logic       first;
  logic       wr;
  logic       ign;
  logic [3:0] bits;
  logic [7:0] sh;
  int         low_n;
  int         fall_n;
  wire st    = scl_q && serial_clock_pin && sda_q && !sda_pin;
  wire sp    = scl_q && serial_clock_pin && !sda_q && sda_pin;
  wire rise  = !scl_q && serial_clock_pin;
  wire fall  = scl_q && !serial_clock_pin;
  wire ninth = rise && bits == 4'h8;
  wire hit   = sh[7:1] == CLIENT_ADDR;
  wire moved = scl_q != serial_clock_pin || sda_q != sda_pin;
  // slack for the client's own input sampling delay
  wire late  = TIMEOUT_EN && low_n + 8 > TIMEOUT_CYCLES;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_q  <= 1'h1;
      sda_q  <= 1'h1;
      first  <= 1'h0;
      wr     <= 1'h0;
      ign    <= 1'h0;
      bits   <= 4'h0;
      sh     <= 8'h00;
      low_n  <= 0;
      fall_n <= 100;
    end else begin
      scl_q  <= serial_clock_pin;
      sda_q  <= sda_pin;
      // only armed time counts, as the client clears its count when off
      low_n  <= (moved || serial_clock_pin || !TIMEOUT_EN) ? 0 : low_n + 1;
      fall_n <= fall ? 0 : fall_n + 1;
      if (st) begin
        bits  <= 4'h0;
        first <= 1'h1;
        ign   <= 1'h0;
      end else if (sp) begin
        wr  <= 1'h0;
        ign <= 1'h0;
      end else if (rise) begin
        bits <= bits + 4'h1;
        if (bits < 4'h8) begin
          sh <= {sh[6:0], sda_pin};
        end
        if (ninth && first) begin
          first <= 1'h0;
          wr    <= hit && !sh[0];
          ign   <= !hit;
        end
      end else if (fall && bits == 4'h9) begin
        bits <= 4'h0;
      end
    end
  end

  // =====
  // properties
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  a_no_stretch: assert property (
    !serial_clock_pin |-> host_scl_oe)
    else $error("clock low without host pull");
  a_addr_ack: assert property (
    ninth && first && hit && !sh[0] |-> !sda_pin)
    else $error("own write address not acknowledged");
  a_addr_nak: assert property (
    ninth && first && !hit |-> sda_pin)
    else $error("foreign address acknowledged");
  a_data_ack: assert property (
    ninth && !first && wr |-> !sda_pin)
    else $error("written byte not acknowledged");
  a_ignore_foreign: assert property (
    ign |-> !dev_sda_oe)
    else $error("data line pulled after foreign address");
  a_stop_quiet: assert property (
    sp |=> !dev_sda_oe [*4])
    else $error("data line pulled after stop");
  a_sda_after_fall: assert property (
    $changed(dev_sda_oe) && !late |-> fall_n <= 4)
    else $error("data line moved away from clock fall");
  a_low_abort: assert property (
    $past(TIMEOUT_EN, 6) && TIMEOUT_EN && low_n >= TIMEOUT_CYCLES + 4
    |-> !dev_sda_oe)
    else $error("data line held past clock-low timeout");

  c_read_addr: cover property (ninth && first && hit && sh[0]);
  c_foreign: cover property (ign);
  c_timeout: cover property (late && low_n >= TIMEOUT_CYCLES);
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// bench: host end drives the client end over the shared bus
// assumes a behavioural register file here and short timeout counts
`timescale 1ns/1ns
`default_nettype none
module testbench
  import smbus_pkg::*;
;
  localparam int TO = 200;
  // =====
  // nets
  logic       mclk;
  logic       rst_n;
  logic       deep_sleep_bit;
  logic       timeout_en;
  logic       op_valid;
  op_t        op_code;
  logic [7:0] op_wdata;
  logic       done;
  logic [7:0] rd_data;
  logic       acked;
  logic [7:0] raddr;
  logic [7:0] rdata;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic       we;
  logic       re;
  logic       op_ready;
  logic       awake;
  int         re_n;
  logic [7:0] mem [256];
  logic [7:0] exp_m [256];
  logic [7:0] bad [3] = '{8'h52, 8'hD0, 8'h40};
  int         fail_count;
  int         checks;

  always #5 mclk = ~mclk;
  assign rdata = mem[raddr];
  always @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      re_n <= re_n + 1;
    end
  end

  smbus_if i_smbus_if ();
  smbus_client #(.TIMEOUT_CYCLES(TO), .IDLE_CYCLES(50)) i_smbus_client (
    .MCLK(mclk), .RST_N(rst_n), .BUS(i_smbus_if.device),
    .DEEP_SLEEP_BIT(deep_sleep_bit), .TIMEOUT_EN(timeout_en),
    .REG_RADDR(raddr), .REG_RDATA(rdata), .REG_RE(re),
    .REG_WADDR(waddr), .REG_WDATA(wdata), .REG_WE(we), .AWAKE(awake));
  smbus_host #(.QUARTER_CYCLES(4)) i_smbus_host (
    .MCLK(mclk), .RST_N(rst_n), .BUS(i_smbus_if.host),
    .OP_VALID(op_valid), .OP_READY(op_ready), .OP_CODE(op_code),
    .OP_WDATA(op_wdata), .DONE(done), .RD_DATA(rd_data), .ACKED(acked));
  smbus_chk #(.TIMEOUT_CYCLES(TO)) i_smbus_chk (
    .MCLK(mclk), .RST_N(rst_n),
    .host_scl_oe(i_smbus_if.host_scl_oe),
    .dev_sda_oe(i_smbus_if.dev_sda_oe),
    .serial_clock_pin(i_smbus_if.serial_clock_pin),
    .sda_pin(i_smbus_if.sda_pin), .TIMEOUT_EN(timeout_en));

  // =====
  // tasks
  task automatic results();
    if (fail_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic op(op_t c, logic [7:0] d);
    int n;
    @(posedge mclk);
    op_valid <= 1'h1;
    op_code  <= c;
    op_wdata <= d;
    @(posedge mclk);
    check("ready", {7'h00, op_ready}, 8'h01);
    op_valid <= 1'h0;
    for (n = 0; n < 400 && done !== 1'h1; n++) begin
      @(negedge mclk);
    end
    if (n == 400) begin
      fail_count++;
      results();
    end
  endtask

  task automatic bus_stop();
    // stop is seen by the client a few cycles before the host finishes
    op(OP_STOP, 8'h00);
    repeat (4) @(negedge mclk);
  endtask

  task automatic wb(logic [7:0] b, logic a);
    op(OP_WRITE, b);
    check("ack", {7'h00, acked}, {7'h00, a});
  endtask

  task automatic bw(logic [7:0] i, logic [7:0] q [$]);
    op(OP_START, 8'h00);
    wb(8'h50, 1'h1);
    wb(i, 1'h1);
    foreach (q[k]) begin
      wb(q[k], 1'h1);
      exp_m[i] = q[k];
      i++;
    end
    bus_stop();
  endtask

  task automatic br(logic [7:0] i, int n, logic s);
    if (s) begin
      op(OP_START, 8'h00);
      wb(8'h50, 1'h1);
      wb(i, 1'h1);
    end
    op(OP_START, 8'h00);
    wb(8'h51, 1'h1);
    for (int k = 1; k <= n; k++) begin
      op(k < n ? OP_READ_ACK : OP_READ_NACK, 8'h00);
      check("read", rd_data, exp_m[i]);
      i++;
    end
    bus_stop();
  endtask

  // =====
  // sequence
  initial begin
    mclk = 1'h0;
    rst_n = 1'h0;
    deep_sleep_bit = 1'h0;
    timeout_en = 1'h0;
    op_valid = 1'h0;
    op_code = OP_START;
    op_wdata = 8'h00;
    fail_count = 0;
    checks = 0;
    re_n = 0;
    for (int k = 0; k < 256; k++) begin
      mem[k] = 8'(k) ^ 8'h5A;
      exp_m[k] = 8'(k) ^ 8'h5A;
    end
    repeat (20) @(posedge mclk);
    rst_n <= 1'h1;
    bw(8'h10, {8'h3C});
    check("ptr", raddr, 8'h11);
    bw(8'hFE, {8'h01, 8'h80, 8'hC3});
    br(8'h10, 1, 1'h1);
    br(8'hFF, 3, 1'h1);
    op(OP_START, 8'h00);
    wb(8'h50, 1'h1);
    wb(8'h20, 1'h1);
    bus_stop();
    check("ptr", raddr, 8'h20);
    br(8'h20, 1, 1'h0);
    foreach (bad[k]) begin
      op(OP_START, 8'h00);
      wb(bad[k], 1'h0);
      wb(8'h10, 1'h0);
      bus_stop();
    end
    br(8'h10, 1, 1'h1);
    // deep sleep: index-only and direct read refused
    @(posedge mclk);
    deep_sleep_bit <= 1'h1;
    op(OP_START, 8'h00);
    wb(8'h50, 1'h1);
    check("awake", {7'h00, awake}, 8'h01);
    wb(8'h30, 1'h1);
    bus_stop();
    check("ptr", raddr, 8'h11);
    check("awake", {7'h00, awake}, 8'h00);
    op(OP_START, 8'h00);
    wb(8'h51, 1'h0);
    bus_stop();
    br(8'h30, 1, 1'h1);
    @(posedge mclk);
    deep_sleep_bit <= 1'h0;
    // client left driving a zero bit while the host holds clock low
    op(OP_START, 8'h00);
    wb(8'h50, 1'h1);
    wb(8'h40, 1'h1);
    op(OP_START, 8'h00);
    wb(8'h51, 1'h1);
    op(OP_READ_ACK, 8'h00);
    check("read", rd_data, exp_m[8'h40]);
    repeat (TO + 100) @(negedge mclk);
    check("hold", {7'h00, i_smbus_if.sda_pin}, 8'h00);
    @(posedge mclk);
    timeout_en <= 1'h1;
    // the quiet-time count only starts once the timeout is armed
    repeat (TO + 20) @(negedge mclk);
    check("abort", {7'h00, i_smbus_if.sda_pin}, 8'h01);
    check("awake", {7'h00, awake}, 8'h00);
    br(8'h40, 1, 1'h1);
    // one fetch per address ack and per host ack across all reads
    check("reads", 8'(re_n), 8'h0A);
    results();
  end
endmodule
`default_nettype wire
